/* File: hw/iap_flash_mailbox_control.sv */
/*
 * Flash mailbox sequencer: AXI4-Lite register file, command acceptance,
 * target selection, flash operation sequencing and completion signalling.
 * Assumes a flash array port that answers flash_req with a one-cycle
 * flash_done, and a CPU core on the same clock that reports fetch source.
 */
`default_nettype none
module iap_flash_mailbox_control #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value.
    parameter logic [7:0] DEVICE_ID = 8'h3c // Arbitrary value.
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_access_pin,
    input wire logic [1:0] fetch_src,
    input wire logic [1:0] block_lock,
    output logic flash_req,
    output logic [6:0] flash_op,
    output logic flash_block,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    input wire logic flash_done,
    input wire logic [7:0] flash_rdata,
    output logic [1:0] block_busy,
    output logic overlay_active,
    output logic osc_enable,
    output logic external_interrupt_one,
    output logic int_one_pin_released
);
    // ****************************************************************
    // Reset release and pin synchronisation.
    // ****************************************************************
    logic rst_meta;
    logic rst_n;
    logic ea_internal;

    // Reset asserts at once and releases after two clock edges.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    iap_sync3 u_ea_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(external_access_pin),
        .sync_out(ea_internal)
    );

    // ****************************************************************
    // Mailbox registers and sequencer state.
    // ****************************************************************
    logic [7:0] flash_config_reg;
    logic [7:0] flash_command_reg;
    logic [7:0] flash_addr_low_reg;
    logic [7:0] flash_addr_high_reg;
    logic [7:0] flash_data_reg;
    logic busy;
    iap_pkg::iap_state_t state;
    iap_pkg::iap_state_t next_state;
    logic overlay;
    logic tgt_block;
    logic tgt_valid;

    iap_target_sel u_target (
        .fetch_src(fetch_src),
        .ea_internal(ea_internal),
        .bank_sel(flash_config_reg[1:0]),
        .addr_high(flash_addr_high_reg),
        .overlay(overlay),
        .tgt_block(tgt_block),
        .tgt_valid(tgt_valid)
    );

    // ****************************************************************
    // AXI4-Lite write channel.
    // ****************************************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic write_go = aw_held && w_held && !s_axi_bvalid;
    wire logic wr_low_lane = w_strb[0];
    wire logic wr_config = write_go && (aw_addr == iap_pkg::OFF_CONFIG);
    wire logic wr_command = write_go && (aw_addr == iap_pkg::OFF_COMMAND);
    wire logic wr_addr_low = write_go && (aw_addr == iap_pkg::OFF_ADDR_LOW);
    wire logic wr_addr_high = write_go &&
        (aw_addr == iap_pkg::OFF_ADDR_HIGH);
    wire logic wr_data = write_go && (aw_addr == iap_pkg::OFF_DATA);
    wire logic wr_mapped = wr_config || wr_command || wr_addr_low ||
        wr_addr_high || wr_data ||
        (aw_addr == iap_pkg::OFF_STATUS);

    // Address and data are captured independently, in either order.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (write_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (write_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Ready is offered while the slot is empty; response after both.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= iap_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (write_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? iap_pkg::RESP_OKAY :
                    iap_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Command acceptance.
    // ****************************************************************
    wire logic [6:0] cmd_code = w_data[6:0];
    wire logic iap_enabled = flash_config_reg[iap_pkg::CFG_IAP_EN_BIT];
    wire logic is_chip = cmd_code == iap_pkg::CMD_CHIP_ERASE;
    wire logic is_sig = cmd_code == iap_pkg::CMD_SIGNATURE;
    wire logic is_verify = cmd_code == iap_pkg::CMD_BYTE_VERIFY;
    wire logic is_prog_erase = (cmd_code == iap_pkg::CMD_BLOCK_ERASE) ||
        (cmd_code == iap_pkg::CMD_SECTOR_ERASE) ||
        (cmd_code == iap_pkg::CMD_BYTE_PROGRAM);
    // Chip erase only from external execution and ignores block locks.
    wire logic chip_ok = is_chip && !ea_internal;
    wire logic block_ok = (is_prog_erase || is_verify) && tgt_valid &&
        !block_lock[tgt_block];
    wire logic cmd_accept = wr_command && wr_low_lane && !busy &&
        iap_enabled && (chip_ok || block_ok || is_sig);
    wire logic needs_osc = is_chip || is_prog_erase;
    wire logic mailbox_free = wr_low_lane && !busy;

    // Mailbox registers: config writes land at any time; the others only while idle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_config_reg <= iap_pkg::REG_RESET;
            flash_command_reg <= iap_pkg::REG_RESET;
            flash_addr_low_reg <= iap_pkg::REG_RESET;
            flash_addr_high_reg <= iap_pkg::REG_RESET;
        end else begin
            if (wr_config && wr_low_lane) begin
                flash_config_reg <= w_data[7:0];
            end
            if (cmd_accept) begin
                flash_command_reg <= w_data[7:0];
            end
            if (wr_addr_low && mailbox_free) begin
                flash_addr_low_reg <= w_data[7:0];
            end
            if (wr_addr_high && mailbox_free) begin
                flash_addr_high_reg <= w_data[7:0];
            end
        end
    end

    // ****************************************************************
    // Operation sequencer.
    // ****************************************************************
    wire logic [6:0] op_code = flash_command_reg[6:0];
    wire logic op_sig = op_code == iap_pkg::CMD_SIGNATURE;
    wire logic op_verify = op_code == iap_pkg::CMD_BYTE_VERIFY;
    wire logic [7:0] sig_byte =
        (flash_addr_low_reg == iap_pkg::SIG_MAKER_ADDR) ? MAKER_ID :
        (flash_addr_low_reg == iap_pkg::SIG_DEVICE_ADDR) ? DEVICE_ID :
        8'h00;

    // Next state of the sequencer.
    always_comb begin
        next_state = state;
        case (state)
            iap_pkg::IAP_IDLE: begin
                if (cmd_accept) begin
                    next_state = iap_pkg::IAP_START;
                end
            end
            iap_pkg::IAP_START: begin
                next_state = op_sig ? iap_pkg::IAP_FINISH :
                    iap_pkg::IAP_WAIT;
            end
            iap_pkg::IAP_WAIT: begin
                if (flash_done) begin
                    next_state = iap_pkg::IAP_FINISH;
                end
            end
            default: begin
                next_state = iap_pkg::IAP_IDLE;
            end
        endcase
    end

    // State, busy flag and the data mailbox.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= iap_pkg::IAP_IDLE;
            busy <= 1'b0;
            flash_data_reg <= iap_pkg::REG_RESET;
        end else begin
            state <= next_state;
            busy <= (next_state != iap_pkg::IAP_IDLE);
            if (state == iap_pkg::IAP_START && op_sig) begin
                flash_data_reg <= sig_byte;
            end else if (state == iap_pkg::IAP_WAIT && flash_done &&
                op_verify) begin
                flash_data_reg <= flash_rdata;
            end else if (wr_data && mailbox_free) begin
                flash_data_reg <= w_data[7:0];
            end
        end
    end

    // ****************************************************************
    // Flash array port and core-facing outputs.
    // ****************************************************************
    // One request pulse per accepted array operation; the fields hold.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_req <= 1'b0;
            flash_op <= 7'h00;
            flash_block <= 1'b0;
            flash_addr <= 16'h0000;
            flash_wdata <= 8'h00;
            block_busy <= 2'h0;
            osc_enable <= 1'b0;
        end else begin
            flash_req <= (state == iap_pkg::IAP_START) && !op_sig;
            if (cmd_accept) begin
                flash_op <= cmd_code;
                flash_block <= tgt_block;
                flash_addr <= {flash_addr_high_reg, flash_addr_low_reg};
                flash_wdata <= flash_data_reg;
                // Chip erase stalls both blocks and signature neither; otherwise only the target stalls fetch.
                block_busy <= is_chip ? 2'h3 :
                    is_sig ? 2'h0 : (tgt_block ? 2'h2 : 2'h1);
                osc_enable <= needs_osc;
            end else if (next_state == iap_pkg::IAP_IDLE) begin
                block_busy <= 2'h0;
                osc_enable <= 1'b0;
            end
        end
    end

    // Completion interrupt, overlay state and pin release to the core.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            external_interrupt_one <= 1'b0;
            int_one_pin_released <= 1'b0;
            overlay_active <= 1'b0;
        end else begin
            external_interrupt_one <= (state == iap_pkg::IAP_FINISH) &&
                flash_command_reg[iap_pkg::CMD_IRQ_BIT];
            int_one_pin_released <= iap_enabled &&
                flash_command_reg[iap_pkg::CMD_IRQ_BIT];
            overlay_active <= overlay;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel.
    // ****************************************************************
    wire logic rd_config = s_axi_araddr == iap_pkg::OFF_CONFIG;
    wire logic rd_status = s_axi_araddr == iap_pkg::OFF_STATUS;
    wire logic rd_command = s_axi_araddr == iap_pkg::OFF_COMMAND;
    wire logic rd_addr_low = s_axi_araddr == iap_pkg::OFF_ADDR_LOW;
    wire logic rd_addr_high = s_axi_araddr == iap_pkg::OFF_ADDR_HIGH;
    wire logic rd_data = s_axi_araddr == iap_pkg::OFF_DATA;
    wire logic [7:0] status_byte = 8'(busy) << iap_pkg::STATUS_BUSY_BIT;
    wire logic [7:0] rd_byte = rd_config ? flash_config_reg :
        rd_status ? status_byte :
        rd_command ? flash_command_reg :
        rd_addr_low ? flash_addr_low_reg :
        rd_addr_high ? flash_addr_high_reg :
        rd_data ? flash_data_reg : 8'h00;
    wire logic rd_mapped = rd_config || rd_status || rd_command ||
        rd_addr_low || rd_addr_high || rd_data;

    // One read at a time; data holds until taken.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= iap_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_mapped ? iap_pkg::RESP_OKAY :
                    iap_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/iap_pkg.sv */
/*
 * Shared constants for the flash mailbox controller: register offsets,
 * field positions, command codes, signature addresses and FSM states.
 * Assumes a single 125 MHz system clock and an AXI4-Lite register bus.
 */
`default_nettype none
package iap_pkg;
    // ****************************************************************
    // Register map, byte addresses on the 32-bit bus.
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_COMMAND = 8'h08;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h0c;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h10;
    localparam logic [7:0] OFF_DATA = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int unsigned CFG_IAP_EN_BIT = 6;
    localparam logic [1:0] BANK_NONE = 2'h0;
    localparam int unsigned STATUS_BUSY_BIT = 2;
    localparam int unsigned CMD_IRQ_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ****************************************************************
    // Command codes in the low seven bits of the command register.
    // ****************************************************************
    localparam logic [6:0] CMD_CHIP_ERASE = 7'h01;
    localparam logic [6:0] CMD_BLOCK_ERASE = 7'h0d;
    localparam logic [6:0] CMD_SECTOR_ERASE = 7'h0b;
    localparam logic [6:0] CMD_BYTE_PROGRAM = 7'h0e;
    localparam logic [6:0] CMD_BYTE_VERIFY = 7'h0c;
    localparam logic [6:0] CMD_SIGNATURE = 7'h0a;
    // ****************************************************************
    // Signature and bank geometry.
    // ****************************************************************
    localparam logic [7:0] SIG_MAKER_ADDR = 8'h30;
    localparam logic [7:0] SIG_DEVICE_ADDR = 8'h31;
    localparam logic [7:0] OVERLAY_LIMIT_HIGH = 8'h20;
    localparam logic [2:0] BLK1_SELECT = 3'h7;
    localparam logic [1:0] SRC_BLOCK0 = 2'h0;
    localparam logic [1:0] SRC_BLOCK1 = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    typedef enum logic [1:0] {
        IAP_IDLE = 2'b00,
        IAP_START = 2'b01,
        IAP_WAIT = 2'b11,
        IAP_FINISH = 2'b10
    } iap_state_t;
endpackage
`default_nettype wire

/* File: hw/iap_sync3.sv */
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk_sys.
 */
`default_nettype none
module iap_sync3 (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic stage_a;
    logic stage_b;
    logic stage_c;

    // The first stage feeds only the second; the output moves once the
    // second and third stages agree.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
            stage_c <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage_a <= async_in;
            stage_b <= stage_a;
            stage_c <= stage_b;
            if (stage_b == stage_c) begin
                sync_out <= stage_c;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/iap_target_sel.sv */
/*
 * Combinational target-block selection for a mailbox command.
 * Assumes fetch_src, bank selection and address are stable on the clock.
 */
`default_nettype none
module iap_target_sel (
    input wire logic [1:0] fetch_src,
    input wire logic ea_internal,
    input wire logic [1:0] bank_sel,
    input wire logic [7:0] addr_high,
    output logic overlay,
    output logic tgt_block,
    output logic tgt_valid
);
    logic low_8k;
    logic ext_blk1;
    logic ext_blk0;
    logic src_visible;

    // Block 1 sits over the lowest 8 KByte only with the overlay on.
    assign overlay = ea_internal && (bank_sel != iap_pkg::BANK_NONE);
    assign low_8k = addr_high < iap_pkg::OVERLAY_LIMIT_HIGH;
    assign ext_blk1 = (overlay && low_8k) ||
        (addr_high[7:5] == iap_pkg::BLK1_SELECT);
    assign ext_blk0 = !ext_blk1 && !addr_high[7];

    // Internal code always aims at the other block; external code by address.
    assign tgt_block = (fetch_src == iap_pkg::SRC_BLOCK0) ? 1'b1 :
        (fetch_src == iap_pkg::SRC_BLOCK1) ? 1'b0 :
        ext_blk1;

    // Hidden code may not originate a block program, erase or verify; a hidden target is fine.
    assign src_visible = (fetch_src == iap_pkg::SRC_BLOCK0) ? ea_internal :
        (fetch_src == iap_pkg::SRC_BLOCK1) ? overlay :
        (fetch_src == iap_pkg::SRC_EXTERNAL);
    assign tgt_valid = src_visible &&
        ((fetch_src != iap_pkg::SRC_EXTERNAL) || ext_blk1 || ext_blk0);
endmodule
`default_nettype wire

/* File: verif/iap_flash_mailbox_control_bench.sv */
/* Self-checking bench for the flash mailbox controller.
   Assumes the flash model and the bound port checker. */
`default_nettype none
module iap_flash_mailbox_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MK = 8'h5a; // Arbitrary value.
    localparam logic [7:0] DV = 8'h3c; // Arbitrary value.
    // Config, command, addr high, pin, source, lock, outcome digits.
    // Outcome 0 or 1 is the target block, 2 any block, 3 refused.
    localparam logic [39:0] ROWS [12] = '{
        40'h00_0e_00_1003,
        40'h40_0e_00_1001,
        40'h41_8e_00_1100,
        40'h40_0e_00_1103,
        40'h40_0b_10_0200,
        40'h41_0b_10_1201,
        40'h40_0d_00_0213,
        40'h40_01_00_0202,
        40'h40_0d_e0_0201,
        40'h40_0e_80_0203,
        40'h41_0e_00_0003,
        40'h40_0c_00_1001};
    logic clk_sys = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, external_access_pin = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h04;
    logic [31:0] s_axi_wdata = 32'h0, got, s_axi_rdata;
    logic [1:0] fetch_src = 2'h0, block_lock = 2'h0, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp, block_busy;
    logic s_axi_rvalid, flash_req, flash_block, flash_done, osc_enable;
    logic external_interrupt_one, ovl, rel;
    logic [6:0] flash_op, prev;
    logic [15:0] flash_addr;
    logic [7:0] flash_rdata, fwd;
    logic [39:0] row;
    int checks = 0, n_mismatch = 0, cyc = 0;
    iap_flash_mailbox_control #(.MAKER_ID(MK), .DEVICE_ID(DV)) DUT (
        .clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready(1'b1), .external_access_pin,
        .fetch_src, .block_lock, .flash_req, .flash_op, .flash_block,
        .flash_addr, .flash_wdata(fwd), .flash_done, .flash_rdata,
        .block_busy, .overlay_active(ovl), .osc_enable,
        .external_interrupt_one, .int_one_pin_released(rel));
    iap_flash_model u_flash (.clk_sys, .flash_req, .lat, .flash_done,
        .flash_rdata);
    // Clock and hang guard.
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bus write: both channels offered together, each dropped when taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        got = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    // Polls the busy flag until the operation ends.
    task automatic wait_idle();
        do rd(iap_pkg::OFF_STATUS); while (got[2] !== 1'b0);
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Reset, table rows, then hand-written awkward cases.
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(iap_pkg::OFF_CONFIG);
        chk(got, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            row = ROWS[i];
            external_access_pin <= row[12];
            fetch_src <= row[9:8];
            block_lock <= row[5:4];
            lat <= 8'(4 + i);
            wr(iap_pkg::OFF_CONFIG, row[39:32]);
            wr(iap_pkg::OFF_ADDR_HIGH, row[23:16]);
            wr(iap_pkg::OFF_ADDR_LOW, 8'h07);
            prev = flash_op;
            wr(iap_pkg::OFF_COMMAND, row[31:24]);
            rd(iap_pkg::OFF_STATUS);
            chk({31'h0, got[2]}, {31'h0, row[3:0] != 4'h3});
            wait_idle();
            chk(32'(ovl), 32'(row[12] && row[33:32] != 2'h0));
            if (row[3:0] == 4'h3) begin
                chk({25'h0, flash_op}, {25'h0, prev});
            end else begin
                chk({25'h0, flash_op}, {25'h0, row[30:24]});
                chk({16'h0, flash_addr}, {16'h0, row[23:16], 8'h07});
                chk(32'(rel), 32'(row[31] && row[38]));
                if (row[1] == 1'b0) chk({31'h0, flash_block}, row[0]);
            end
            $display("row %0d done", i);
        end
        wr(iap_pkg::OFF_COMMAND, 8'h0e);
        wr(iap_pkg::OFF_COMMAND, 8'h0b);
        wait_idle();
        chk({25'h0, flash_op}, 32'h0e);
        // The last verify left the model's read byte in the data mailbox.
        chk({24'h0, fwd}, 32'ha5);
        $display("busy refusal done");
        for (int j = 0; j < 2; j++) begin
            wr(iap_pkg::OFF_ADDR_LOW, 8'(8'h30 + j));
            wr(iap_pkg::OFF_COMMAND, {1'b0, iap_pkg::CMD_SIGNATURE});
            wait_idle();
            rd(iap_pkg::OFF_DATA);
            chk(got, {24'h0, (j == 1) ? DV : MK});
        end
        $display("signature done");
        rd(8'h40);
        chk({30'h0, resp}, {30'h0, iap_pkg::RESP_SLVERR});
        wr(8'h44, 8'h01);
        chk({30'h0, resp}, {30'h0, iap_pkg::RESP_SLVERR});
        $display("unmapped done");
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: verif/iap_flash_mailbox_control_monitor.sv */
/* Port checker for the flash mailbox controller.
   Assumes it is bound to the top module and sees only its ports. */
`default_nettype none
module iap_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic flash_req,
    input wire logic flash_block,
    input wire logic flash_done,
    input wire logic [6:0] flash_op,
    input wire logic [1:0] fetch_src,
    input wire logic [1:0] block_busy,
    input wire logic osc_enable,
    input wire logic external_interrupt_one
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ****************************************
    // Start, busy, oscillator and target checks.
    // ****************************************
    property p_req; flash_req |=> !flash_req; endproperty
    a_req: assert property (p_req) else $error("start too long");
    property p_req_busy; flash_req |-> $past(|block_busy); endproperty
    a_req_busy: assert property (p_req_busy) else $error("no busy");
    property p_done; flash_done |-> ##2 block_busy == 2'h0; endproperty
    a_done: assert property (p_done) else $error("busy stuck");
    property p_osc; osc_enable |-> |block_busy; endproperty
    a_osc: assert property (p_osc) else $error("osc while idle");
    property p_osc_off; flash_done |-> ##2 !osc_enable; endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc on");
    // A signature read never stalls a block, so only idle and pulse width.
    property p_irq;
        external_interrupt_one |-> block_busy == 2'h0 ##1
            !external_interrupt_one;
    endproperty
    a_irq: assert property (p_irq) else $error("irq timing");
    property p_owner;
        flash_req && $past(fetch_src, 2) != 2'h2 |->
            flash_block == !$past(fetch_src[0], 2);
    endproperty
    a_owner: assert property (p_owner) else $error("own block");
    // Chip erase may stall both blocks; any other operation at most one.
    property p_one_blk; flash_op != 7'h01 |-> block_busy != 2'h3; endproperty
    a_one_blk: assert property (p_one_blk) else $error("both busy");
endmodule
bind iap_flash_mailbox_control iap_chk u_chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .flash_req(flash_req), .flash_block(flash_block),
    .flash_done(flash_done), .flash_op(flash_op), .fetch_src(fetch_src),
    .block_busy(block_busy), .osc_enable(osc_enable),
    .external_interrupt_one(external_interrupt_one));
`default_nettype wire

/* File: verif/iap_flash_model.sv */
/* Flash array stand-in: answers each start strobe with a done strobe.
   Assumes the strobe is one cycle long and lat is at least one. */
`default_nettype none
module iap_flash_model (
    input wire logic clk_sys,
    input wire logic flash_req,
    input wire logic [7:0] lat,
    output logic flash_done,
    output logic [7:0] flash_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Read byte toggles outside done so a stale value matches a5 on alternate cycles at most.
    always @(posedge clk_sys) begin
        flash_done <= 1'b0;
        flash_rdata <= ~flash_rdata;
        if (flash_req) begin
            cnt <= int'(lat);
        end else if (cnt == 1) begin
            flash_done <= 1'b1;
            flash_rdata <= 8'ha5;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    initial flash_rdata = 8'h00;
endmodule
`default_nettype wire
